// ---- hdl/lonr_pkg.sv ----
// constants, register map and state codes of the threshold/offset/nvm register bank
// Summary of operation
// (RULE1) thresholds are 16-bit signed codes, 7.8125 mdegC per count, span +-256 degC
// (RULE2) negative thresholds use two's complement, same as the temperature result
// (RULE3) upper threshold reloads from nvm after reset or general call; factory 6000h; the code ignores a general call while busy
// (RULE4) lower threshold reloads from nvm after reset; factory code 8000h
// (RULE5) while locked, writes change only the volatile registers, nvm untouched
// (RULE6) while unlocked, a write to a programmable register also programs nvm; the code skips nvm for writes made while busy
// (RULE7) unlock register carries a read-only busy bit mirroring the config busy bit
// (RULE8) busy is one during nvm programming or the reset reload
// (RULE9) busy returns to zero once the last nvm transaction has finished
// (RULE10) scratch word one is nvm backed; a locked write changes only the register
// (RULE11) an unlocked scratch write programs the matching nvm location
// (RULE12) scratch words come preloaded from nvm with an identifier the host may overwrite
// (RULE13) host should not reprogram scratch word one, it holds traceability data
// (RULE14) scratch word two behaves exactly like scratch word one
// (RULE15) calibration offset is added to the linearized result before it is stored
// (RULE16) offset uses the same step and span as the temperature result
// (RULE17) an overflowing sum saturates to the maximum or minimum code
// (RULE18) in alert mode a result above the upper threshold sets the high flag
// (RULE19) in alert mode a result below the lower threshold sets the low flag
// (RULE20) host should wait for busy low before another unlocked write
// (RULE21) unused unlock register bits read zero and ignore writes
package lonr_pkg;

    localparam int          DATA_W          = 16;
    localparam int          ADDR_W          = 8;

    // register addresses
    localparam logic [7:0]  ADDR_UPPER      = 8'h02;
    localparam logic [7:0]  ADDR_LOWER      = 8'h03;
    localparam logic [7:0]  ADDR_UNLOCK     = 8'h04;
    localparam logic [7:0]  ADDR_SCRATCH1   = 8'h05;
    localparam logic [7:0]  ADDR_SCRATCH2   = 8'h06;
    localparam logic [7:0]  ADDR_OFFSET     = 8'h07;

    // reset values
    localparam logic [15:0] UPPER_RESET     = 16'h6000;
    localparam logic [15:0] LOWER_RESET     = 16'h8000;
    localparam logic [15:0] OFFSET_RESET    = 16'h0000;
    localparam logic [15:0] SCRATCH_RESET   = 16'h0000;
    localparam logic [15:0] ZERO_WORD       = 16'h0000;

    // unlock register fields
    localparam int          UNLOCK_BIT      = 15;
    localparam int          BUSY_BIT        = 14;

    // saturation limits of the result code
    localparam logic [15:0] RESULT_MAX      = 16'h7fff;
    localparam logic [15:0] RESULT_MIN      = 16'h8000;

    // reload sequence: words fetched from nvm after reset
    localparam logic [1:0]  LOAD_FIRST      = 2'h0;
    localparam logic [1:0]  LOAD_LAST       = 2'h3;
    localparam logic [1:0]  LOAD_STEP       = 2'h1;

    // controller states, one-hot
    typedef enum logic [3:0] {
        LONR_LOAD_REQ  = 4'h1,
        LONR_LOAD_WAIT = 4'h2,
        LONR_IDLE      = 4'h4,
        LONR_PROG_WAIT = 4'h8
    } lonr_state_t;

endpackage : lonr_pkg

// ---- hdl/lonr_regs.sv ----
// threshold, nvm unlock, scratch and calibration offset register bank
`timescale 1ns/1ps
module lonr_regs (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // register access from the serial front end
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    output logic             reg_rd_valid,
    // general-call reset request
    input  wire logic        gcall_reset,
    // non-volatile storage port
    output logic             nvm_rd_req,
    output logic             nvm_wr_req,
    output logic      [7:0]  nvm_addr,
    output logic      [15:0] nvm_wdata,
    input  wire logic [15:0] nvm_rdata,
    input  wire logic        nvm_ack,
    // busy, mirrored into the configuration register
    output logic             nvm_busy,
    // linearized temperature in, offset-corrected result out
    input  wire logic [15:0] raw_result,
    input  wire logic        raw_valid,
    output logic      [15:0] result,
    output logic             result_valid,
    // alert flags
    input  wire logic        alert_mode,
    input  wire logic        flag_clear,
    output logic             high_alert,
    output logic             low_alert,
    // register contents for the rest of the sensor
    output logic      [15:0] upper_threshold,
    output logic      [15:0] lower_threshold
);

    // complete state of the bank
    typedef struct packed {
        lonr_pkg::lonr_state_t state;
        logic [1:0]            load_idx;
        logic [15:0]           upper;
        logic [15:0]           lower;
        logic                  unlock;
        logic [15:0]           scratch1;
        logic [15:0]           scratch2;
        logic [15:0]           offset;
        logic                  busy;
        logic                  nvm_rd;
        logic                  nvm_wr;
        logic [7:0]            nvm_addr;
        logic [15:0]           nvm_wdata;
        logic [15:0]           rdata;
        logic                  rd_valid;
        logic [15:0]           result;
        logic                  result_valid;
        logic                  high_alert;
        logic                  low_alert;
    } lonr_regs_t;

    lonr_regs_t  st;
    lonr_regs_t  next_st;
    logic [15:0] corrected;
    logic        prog_addr;
    logic [7:0]  load_addr;
    logic [15:0] read_word;

    // offset correction; saturation hides overflow of extreme offsets
    lonr_sat_add #(
        .W   (lonr_pkg::DATA_W)
    ) u_sat_add (
        .a   (raw_result),
        .b   (st.offset),
        .sum (corrected)
    );

    // addresses that own an nvm location
    always_comb begin
        prog_addr = (reg_addr == lonr_pkg::ADDR_UPPER)    ||
                    (reg_addr == lonr_pkg::ADDR_LOWER)    ||
                    (reg_addr == lonr_pkg::ADDR_SCRATCH1) ||
                    (reg_addr == lonr_pkg::ADDR_SCRATCH2);
    end

    // nvm word fetched at each step of the reload
    always_comb begin
        case (st.load_idx)
            2'h0:    load_addr = lonr_pkg::ADDR_UPPER;
            2'h1:    load_addr = lonr_pkg::ADDR_LOWER;
            2'h2:    load_addr = lonr_pkg::ADDR_SCRATCH1;
            default: load_addr = lonr_pkg::ADDR_SCRATCH2;
        endcase
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        case (reg_addr)
            lonr_pkg::ADDR_UPPER:    read_word = st.upper;
            lonr_pkg::ADDR_LOWER:    read_word = st.lower;
            lonr_pkg::ADDR_UNLOCK: begin
                read_word = lonr_pkg::ZERO_WORD; // RULE21
                read_word[lonr_pkg::UNLOCK_BIT] = st.unlock;
                read_word[lonr_pkg::BUSY_BIT]   = st.busy; // RULE7
            end
            lonr_pkg::ADDR_SCRATCH1: read_word = st.scratch1;
            lonr_pkg::ADDR_SCRATCH2: read_word = st.scratch2;
            lonr_pkg::ADDR_OFFSET:   read_word = st.offset;
            default:                 read_word = lonr_pkg::ZERO_WORD;
        endcase
    end

    // next-state logic of the whole bank
    always_comb begin
        next_st = st;
        next_st.rd_valid     = 1'b0;
        next_st.result_valid = 1'b0;

        // register reads answer one cycle later
        if (reg_rd) begin
            next_st.rdata    = read_word;
            next_st.rd_valid = 1'b1;
        end

        // host writes update the volatile copy unless a reload word in the same cycle overrides it; a general call in that cycle overrides only an unlock write
        if (reg_wr) begin
            case (reg_addr)
                lonr_pkg::ADDR_UPPER:    next_st.upper    = reg_wdata; // RULE1
                lonr_pkg::ADDR_LOWER:    next_st.lower    = reg_wdata; // RULE2
                lonr_pkg::ADDR_UNLOCK:   next_st.unlock   = reg_wdata[lonr_pkg::UNLOCK_BIT]; // RULE21
                lonr_pkg::ADDR_SCRATCH1: next_st.scratch1 = reg_wdata; // RULE10
                lonr_pkg::ADDR_SCRATCH2: next_st.scratch2 = reg_wdata; // RULE14
                lonr_pkg::ADDR_OFFSET:   next_st.offset   = reg_wdata; // RULE16
                default: begin
                end
            endcase
        end

        // result path: offset added before the result is stored
        if (raw_valid) begin
            next_st.result       = corrected; // RULE15
            next_st.result_valid = 1'b1;
        end

        // flags compare the stored code; clear loses to a new event
        if (flag_clear) begin
            next_st.high_alert = 1'b0;
            next_st.low_alert  = 1'b0;
        end
        if (raw_valid && alert_mode) begin
            if ($signed(corrected) > $signed(st.upper)) begin
                next_st.high_alert = 1'b1; // RULE18
            end
            if ($signed(corrected) < $signed(st.lower)) begin
                next_st.low_alert = 1'b1; // RULE19
            end
        end

        // nvm controller
        case (st.state)
            lonr_pkg::LONR_LOAD_REQ: begin
                next_st.busy     = 1'b1; // RULE8
                next_st.nvm_rd   = 1'b1;
                next_st.nvm_addr = load_addr;
                next_st.state    = lonr_pkg::LONR_LOAD_WAIT;
            end
            lonr_pkg::LONR_LOAD_WAIT: begin
                if (nvm_ack) begin
                    next_st.nvm_rd = 1'b0;
                    case (st.load_idx)
                        2'h0:    next_st.upper    = nvm_rdata; // RULE3
                        2'h1:    next_st.lower    = nvm_rdata; // RULE4
                        2'h2:    next_st.scratch1 = nvm_rdata; // RULE12
                        default: next_st.scratch2 = nvm_rdata; // RULE12
                    endcase
                    if (st.load_idx == lonr_pkg::LOAD_LAST) begin
                        next_st.busy  = 1'b0; // RULE9
                        next_st.state = lonr_pkg::LONR_IDLE;
                    end else begin
                        next_st.load_idx = st.load_idx + lonr_pkg::LOAD_STEP;
                        next_st.state    = lonr_pkg::LONR_LOAD_REQ;
                    end
                end
            end
            lonr_pkg::LONR_IDLE: begin
                if (gcall_reset) begin
                    // general call restarts the reload and relocks programming
                    next_st.unlock   = 1'b0;
                    next_st.load_idx = lonr_pkg::LOAD_FIRST;
                    next_st.busy     = 1'b1; // RULE8
                    next_st.state    = lonr_pkg::LONR_LOAD_REQ; // RULE3
                end else if (reg_wr && prog_addr && st.unlock) begin // RULE5
                    // locked writes never reach here, so nvm stays untouched
                    next_st.nvm_wr    = 1'b1; // RULE6
                    next_st.nvm_addr  = reg_addr; // RULE11
                    next_st.nvm_wdata = reg_wdata;
                    next_st.busy      = 1'b1; // RULE8
                    next_st.state     = lonr_pkg::LONR_PROG_WAIT;
                end
            end
            lonr_pkg::LONR_PROG_WAIT: begin
                // unlocked writes while busy update only the register
                if (nvm_ack) begin
                    next_st.nvm_wr = 1'b0;
                    next_st.busy   = 1'b0; // RULE9
                    next_st.state  = lonr_pkg::LONR_IDLE;
                end
            end
            default: begin
                next_st.state = lonr_pkg::LONR_IDLE;
                next_st.busy  = 1'b0;
            end
        endcase
    end

    // state register; reset values stand until the reload overwrites them
    always_ff @(posedge clock) begin
        if (!resetn) begin
            st.state        <= lonr_pkg::LONR_LOAD_REQ;
            st.load_idx     <= lonr_pkg::LOAD_FIRST;
            st.upper        <= lonr_pkg::UPPER_RESET;
            st.lower        <= lonr_pkg::LOWER_RESET;
            st.unlock       <= 1'b0;
            st.scratch1     <= lonr_pkg::SCRATCH_RESET;
            st.scratch2     <= lonr_pkg::SCRATCH_RESET;
            st.offset       <= lonr_pkg::OFFSET_RESET;
            st.busy         <= 1'b1;
            st.nvm_rd       <= 1'b0;
            st.nvm_wr       <= 1'b0;
            st.nvm_addr     <= lonr_pkg::ADDR_UPPER;
            st.nvm_wdata    <= lonr_pkg::ZERO_WORD;
            st.rdata        <= lonr_pkg::ZERO_WORD;
            st.rd_valid     <= 1'b0;
            st.result       <= lonr_pkg::ZERO_WORD;
            st.result_valid <= 1'b0;
            st.high_alert   <= 1'b0;
            st.low_alert    <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state flops
    assign reg_rdata       = st.rdata;
    assign reg_rd_valid    = st.rd_valid;
    assign nvm_rd_req      = st.nvm_rd;
    assign nvm_wr_req      = st.nvm_wr;
    assign nvm_addr        = st.nvm_addr;
    assign nvm_wdata       = st.nvm_wdata;
    assign nvm_busy        = st.busy;
    assign result          = st.result;
    assign result_valid    = st.result_valid;
    assign high_alert      = st.high_alert;
    assign low_alert       = st.low_alert;
    assign upper_threshold = st.upper;
    assign lower_threshold = st.lower;

    // checks on the bank's own behaviour
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    a_busy_after_reset: assert property ( // RULE8
        $rose(resetn) |-> nvm_busy ##1 (nvm_busy && nvm_rd_req))
        else $error("busy or reload missing after reset");

    a_locked_no_prog: assert property ( // RULE5
        (reg_wr && !st.unlock && !nvm_wr_req) |=> !nvm_wr_req)
        else $error("nvm programmed while locked");

    a_unlocked_prog: assert property ( // RULE6
        (reg_wr && prog_addr && st.unlock && st.state == lonr_pkg::LONR_IDLE && !gcall_reset)
        |=> (nvm_wr_req && nvm_busy && nvm_addr == $past(reg_addr)
             && nvm_wdata == $past(reg_wdata)))
        else $error("unlocked write did not start programming");

    a_busy_release: assert property ( // RULE9
        (nvm_ack && st.state == lonr_pkg::LONR_PROG_WAIT) |=> (!nvm_busy && !nvm_wr_req))
        else $error("busy not cleared after programming");

    a_busy_mirror: assert property ( // RULE7
        (reg_rd && reg_addr == lonr_pkg::ADDR_UNLOCK)
        |=> (reg_rdata[lonr_pkg::BUSY_BIT] == $past(nvm_busy) && reg_rdata[13:0] == 14'h0000))
        else $error("unlock readback wrong");

    a_scratch_store: assert property ( // RULE10
        (reg_wr && reg_addr == lonr_pkg::ADDR_SCRATCH1 && st.state == lonr_pkg::LONR_IDLE)
        |=> st.scratch1 == $past(reg_wdata))
        else $error("scratch write lost");

    a_sat_limits: assert property ( // RULE17
        (raw_valid && !raw_result[15] && !st.offset[15]
         && (17'(raw_result) + 17'(st.offset)) > 17'h07fff)
        |=> (result == lonr_pkg::RESULT_MAX && result_valid))
        else $error("positive overflow not saturated");

    a_sat_low_limit: assert property ( // RULE17
        (raw_valid && raw_result[15] && st.offset[15]
         && (17'(raw_result) + 17'(st.offset)) < 17'h18000)
        |=> (result == lonr_pkg::RESULT_MIN && result_valid))
        else $error("negative overflow not saturated");

    a_high_flag: assert property ( // RULE18
        (raw_valid && alert_mode && $signed(corrected) > $signed(st.upper))
        |=> (high_alert && result_valid))
        else $error("high flag not set");

    a_low_flag: assert property ( // RULE19
        (raw_valid && alert_mode && $signed(corrected) < $signed(st.lower))
        |=> (low_alert && result_valid))
        else $error("low flag not set");

    a_upper_reload: assert property ( // RULE3
        (nvm_ack && st.state == lonr_pkg::LONR_LOAD_WAIT && st.load_idx == lonr_pkg::LOAD_FIRST)
        |=> upper_threshold == $past(nvm_rdata))
        else $error("upper threshold not reloaded");

    a_lower_reload: assert property ( // RULE4
        (nvm_ack && st.state == lonr_pkg::LONR_LOAD_WAIT
         && st.load_idx == lonr_pkg::LOAD_FIRST + lonr_pkg::LOAD_STEP)
        |=> lower_threshold == $past(nvm_rdata))
        else $error("lower threshold not reloaded");

    a_upper_store: assert property ( // RULE1
        (reg_wr && reg_addr == lonr_pkg::ADDR_UPPER && st.state == lonr_pkg::LONR_IDLE)
        |=> upper_threshold == $past(reg_wdata))
        else $error("upper threshold write lost");

    a_lower_store: assert property ( // RULE2
        (reg_wr && reg_addr == lonr_pkg::ADDR_LOWER && st.state == lonr_pkg::LONR_IDLE)
        |=> lower_threshold == $past(reg_wdata))
        else $error("lower threshold write lost");

    a_offset_store: assert property ( // RULE16
        (reg_wr && reg_addr == lonr_pkg::ADDR_OFFSET) |=> st.offset == $past(reg_wdata))
        else $error("offset write lost");

    a_result_pulse: assert property ( // RULE15
        raw_valid |=> (result_valid && result == $past(corrected)))
        else $error("result not stored after sample");

    a_busy_covers_req: assert property ( // RULE8
        (nvm_rd_req || nvm_wr_req) |-> nvm_busy)
        else $error("nvm request without busy");

endmodule : lonr_regs

// ---- hdl/lonr_sat_add.sv ----
// saturating signed adder for result plus calibration offset
`timescale 1ns/1ps
module lonr_sat_add #(
    parameter int W = 16
) (
    // operands
    input  wire logic [W-1:0] a,
    input  wire logic [W-1:0] b,
    // saturated sum
    output logic      [W-1:0] sum
);

    logic [W:0] wide;

    // one guard bit shows overflow when it differs from the sign bit
    always_comb begin
        wide = {a[W-1], a} + {b[W-1], b};
        if (wide[W] != wide[W-1]) begin
            sum = wide[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}}; // RULE17
        end else begin
            sum = wide[W-1:0];
        end
    end

endmodule : lonr_sat_add

// ---- test/lonr_nvm_model.sv ----
// behavioural non-volatile word store answering the register bank req/ack port
`timescale 1ns/1ps
module lonr_nvm_model (
    // clock
    input  wire logic        clock,
    // request side, driven by the register bank
    input  wire logic        rd_req,
    input  wire logic        wr_req,
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    // cycles waited before each acknowledge
    input  wire logic [3:0]  lat,
    // answer side
    output logic      [15:0] rdata,
    output logic             ack,
    output logic      [7:0]  wr_count
);
    logic [15:0] mem [0:7];
    logic [3:0]  wait_cnt;

    // factory contents; the identifier words are arbitrary
    initial begin
        mem[2]   = 16'h6000;
        mem[3]   = 16'h8000;
        mem[5]   = 16'h1d2e;
        mem[6]   = 16'h3f4a;
        rdata    = 16'h0f0f;
        ack      = 1'b0;
        wait_cnt = 4'h0;
        wr_count = 8'h00;
    end

    // one request at a time; read data toggles except on a read answer so stale data never matches
    always @(posedge clock) begin
        ack   <= 1'b0;
        rdata <= ~rdata;
        if ((rd_req || wr_req) && !ack) begin
            if (wait_cnt >= lat) begin
                ack      <= 1'b1;
                wait_cnt <= 4'h0;
                if (wr_req) begin
                    mem[addr[2:0]] <= wdata;
                    wr_count       <= wr_count + 8'h01;
                end else begin
                    rdata <= mem[addr[2:0]];
                end
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule : lonr_nvm_model

// ---- test/test_lonr_regs.sv ----
// self-checking bench of the threshold, nvm unlock, scratch and offset register bank
`timescale 1ns/1ps
module test_lonr_regs;
    logic        clock, resetn, reg_wr, reg_rd, reg_rd_valid, gcall_reset;
    logic [7:0]  reg_addr, nvm_addr, wr_count;
    logic [15:0] reg_wdata, reg_rdata, nvm_wdata, nvm_rdata, raw_result, result;
    logic [15:0] upper_threshold, lower_threshold;
    logic        nvm_rd_req, nvm_wr_req, nvm_ack, nvm_busy, raw_valid, result_valid;
    logic        alert_mode, flag_clear, high_alert, low_alert;
    logic [3:0]  nvm_lat;
    int          fail_count, cmp_count;
    logic [7:0]  addr_t [5] = '{8'h02, 8'h03, 8'h05, 8'h06, 8'h07};
    logic [15:0] ofs_t [5] = '{16'h0010, 16'h0200, 16'hff00, 16'hffe0, 16'h7fff};
    logic [15:0] raw_t [5] = '{16'h0100, 16'h7f00, 16'h8050, 16'h0010, 16'h0001};
    logic [15:0] exp_t [5] = '{16'h0110, 16'h7fff, 16'h8000, 16'hfff0, 16'h7fff};

    lonr_regs u_lonr_regs (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid), .gcall_reset(gcall_reset), .nvm_rd_req(nvm_rd_req),
        .nvm_wr_req(nvm_wr_req), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata),
        .nvm_rdata(nvm_rdata), .nvm_ack(nvm_ack), .nvm_busy(nvm_busy),
        .raw_result(raw_result), .raw_valid(raw_valid), .result(result),
        .result_valid(result_valid), .alert_mode(alert_mode), .flag_clear(flag_clear),
        .high_alert(high_alert), .low_alert(low_alert),
        .upper_threshold(upper_threshold), .lower_threshold(lower_threshold));

    lonr_nvm_model u_lonr_nvm_model (.clock(clock), .rd_req(nvm_rd_req),
        .wr_req(nvm_wr_req), .addr(nvm_addr), .wdata(nvm_wdata), .lat(nvm_lat),
        .rdata(nvm_rdata), .ack(nvm_ack), .wr_count(wr_count));

    // 50 MHz clock
    always #10 clock = ~clock;

    task automatic report_and_stop();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("wrong value %s: expected %h, seen %h", nm, exp, got);
            fail_count++;
        end
    endtask : check

    // one-cycle write strobe, data held with it
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask : reg_write

    // read data is taken in the cycle its valid pulse stands
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1;
        check("reg_rd_valid", 16'h0001, {15'h0, reg_rd_valid});
        check($sformatf("register %h", a), exp, reg_rdata);
    endtask : rd_chk

    // bounded wait for the busy level; running out ends the run
    task automatic wait_busy(input logic val);
        int n;
        n = 0;
        while (nvm_busy !== val && n < 200) begin
            @(posedge clock);
            #1;
            n++;
        end
        check("nvm_busy", {15'h0, val}, {15'h0, nvm_busy});
        if (nvm_busy !== val) report_and_stop();
    endtask : wait_busy

    // one sample through the offset adder; flags are checked with the result
    task automatic raw_chk(input logic [15:0] raw, input logic [15:0] exp,
                           input logic hi, input logic lo);
        @(posedge clock);
        raw_result <= raw;
        raw_valid  <= 1'b1;
        @(posedge clock);
        raw_valid  <= 1'b0;
        #1;
        check("result", exp, result);
        check("result_valid", 16'h0001, {15'h0, result_valid});
        check("high_alert", {15'h0, hi}, {15'h0, high_alert});
        check("low_alert", {15'h0, lo}, {15'h0, low_alert});
    endtask : raw_chk

    task automatic pulse(input logic gcall);
        @(posedge clock);
        gcall_reset <= gcall;
        flag_clear  <= ~gcall;
        @(posedge clock);
        gcall_reset <= 1'b0;
        flag_clear  <= 1'b0;
    endtask : pulse

    // watchdog against a hang anywhere in the sequence
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        report_and_stop();
    end

    initial begin
        clock = 0; resetn = 0; reg_addr = 8'h00; reg_wdata = 16'h0000;
        reg_wr = 0; reg_rd = 0; gcall_reset = 0; raw_result = 16'h0000;
        raw_valid = 0; alert_mode = 0; flag_clear = 0; nvm_lat = 4'h0;
        fail_count = 0; cmp_count = 0;
        repeat (10) @(posedge clock);
        #1;
        check("upper_threshold", 16'h6000, upper_threshold);
        check("lower_threshold", 16'h8000, lower_threshold);
        check("nvm_busy", 16'h0001, {15'h0, nvm_busy});
        @(posedge clock);
        resetn <= 1'b1;
        wait_busy(1'b0);
        rd_chk(8'h02, 16'h6000);
        rd_chk(8'h03, 16'h8000);
        rd_chk(8'h05, 16'h1d2e);
        rd_chk(8'h06, 16'h3f4a);
        rd_chk(8'h04, 16'h0000);
        rd_chk(8'h07, 16'h0000);
        rd_chk(8'h08, 16'h0000);
        // locked writes stay volatile, negative codes kept as written
        for (int i = 0; i < 5; i++) begin
            reg_write(addr_t[i], 16'hc3a0 + 16'(i));
            rd_chk(addr_t[i], 16'hc3a0 + 16'(i));
        end
        check("upper_threshold", 16'hc3a0, upper_threshold);
        check("nvm writes", 16'h0000, {8'h00, wr_count});
        reg_write(8'h04, 16'hffff);
        rd_chk(8'h04, 16'h8000);
        nvm_lat = 4'h6;
        // unlocked writes program nvm; scratch word one is left alone
        reg_write(8'h02, 16'h0180);
        rd_chk(8'h04, 16'hc000);
        wait_busy(1'b0);
        reg_write(8'h06, 16'h5a5a);
        rd_chk(8'h04, 16'hc000);
        wait_busy(1'b0);
        check("nvm writes", 16'h0002, {8'h00, wr_count});
        reg_write(8'h04, 16'h0000);
        reg_write(8'h02, 16'h0011);
        reg_write(8'h03, 16'h1234);
        reg_write(8'h06, 16'h0000);
        check("nvm writes", 16'h0002, {8'h00, wr_count});
        // general call reloads the stored words over the volatile ones
        pulse(1'b1);
        wait_busy(1'b1);
        wait_busy(1'b0);
        rd_chk(8'h02, 16'h0180);
        rd_chk(8'h03, 16'h8000);
        rd_chk(8'h06, 16'h5a5a);
        rd_chk(8'h05, 16'h1d2e);
        rd_chk(8'h04, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            reg_write(8'h07, ofs_t[i]);
            raw_chk(raw_t[i], exp_t[i], 1'b0, 1'b0);
        end
        reg_write(8'h07, 16'h0000);
        reg_write(8'h02, 16'h0100);
        reg_write(8'h03, 16'hff00);
        alert_mode <= 1'b1;
        raw_chk(16'h0100, 16'h0100, 1'b0, 1'b0);
        raw_chk(16'h0200, 16'h0200, 1'b1, 1'b0);
        pulse(1'b0);
        raw_chk(16'hff00, 16'hff00, 1'b0, 1'b0);
        raw_chk(16'hfe00, 16'hfe00, 1'b0, 1'b1);
        pulse(1'b0);
        alert_mode <= 1'b0;
        raw_chk(16'h0200, 16'h0200, 1'b0, 1'b0);
        report_and_stop();
    end
endmodule : test_lonr_regs
